// ---- core/ulfc_defines.vh ----
// Constants of the UART line format control block.
// Included by bare name by every design file of the block.
`ifndef ULFC_DEFINES_VH
`define ULFC_DEFINES_VH

`define ULFC_OFF_LC     4'h0
`define ULFC_OFF_DIV    4'h4
`define ULFC_OFF_DATA   4'h8
`define ULFC_OFF_STAT   4'hC

`define ULFC_LC_DLAB    7
`define ULFC_LC_BRK     6
`define ULFC_LC_FPAR    5
`define ULFC_LC_EVEN    4
`define ULFC_LC_PEN     3
`define ULFC_LC_STB     2

`define ULFC_LC_RST     8'h00
`define ULFC_DIV_RST    16'h0001

`define ULFC_OVS        6'h10
`define ULFC_HALF       6'h08
`define ULFC_STOP1      6'h10
`define ULFC_STOP15     6'h18
`define ULFC_STOP2      6'h20

`define ULFC_RESP_OK    2'h0
`define ULFC_RESP_ERR   2'h2

`endif

// ---- core/ulfc_top.v ----
// UART channel with the line control register, reached over AXI4-Lite.
// Assumes rxd_in is asynchronous to aclk; txd_out idles high.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ulfc_defines.vh"

// Function
// [RULE1] Bit 7 opens the divisor latch
// [RULE2] Bit 6 holds transmit line low
// [RULE3] Bit 3 adds and checks parity
// [RULE4] Bit 3 clear: no parity at all
// [RULE5] Bit 4 picks odd or even parity
// [RULE6] Bit 5 forces parity, inverse of bit 4
// [RULE7] Bit 2: one, one-and-half, two stops
// [RULE8] Bits 1:0 pick five to eight bits
// [RULE9] Receiver checks only the first stop bit
module ulfc_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        rxd_in,
    output reg         txd_out
);
    localparam R_IDLE  = 3'h0;
    localparam R_START = 3'h1;
    localparam R_DATA  = 3'h2;
    localparam R_PAR   = 3'h3;
    localparam R_STOP  = 3'h4;

    reg  [7:0]  line_control_r;
    reg  [15:0] div_r;
    reg  [15:0] bcnt_r;
    reg         tick_r;
    reg         aw_have_r;
    reg         w_have_r;
    reg  [3:0]  awaddr_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         rx_s1_r;
    reg         rx_s2_r;
    reg         rx_s3_r;
    reg         rxf_r;
    reg  [2:0]  rstate_r;
    reg  [5:0]  rtcnt_r;
    reg  [2:0]  ridx_r;
    reg  [7:0]  rsh_r;
    reg  [7:0]  rlc_r;
    reg         rperr_r;
    reg  [7:0]  rx_data_r;
    reg         rx_valid_r;
    reg         perr_r;
    reg         ferr_r;
    wire        tx_ready;
    wire        txd_raw;
    wire        wr_go;
    wire [2:0]  wsel;
    wire        tx_load;
    wire        rx_done;
    wire        rx_read;

    // Returns 0..3 for the mapped words, 4 for anything else
    function [2:0] ulfc_sel;
        input [3:0] addr;
        begin
            if (addr == `ULFC_OFF_LC)
                ulfc_sel = 3'h0;
            else if (addr == `ULFC_OFF_DIV)
                ulfc_sel = 3'h1;
            else if (addr == `ULFC_OFF_DATA)
                ulfc_sel = 3'h2;
            else if (addr == `ULFC_OFF_STAT)
                ulfc_sel = 3'h3;
            else
                ulfc_sel = 3'h4;
        end
    endfunction

    // Parity bit for a character under a given format
    function ulfc_par;
        input [7:0] lc;
        input [7:0] d;
        reg   [7:0] m;
        begin
            case (lc[1:0]) // see [RULE8]
                2'h0:    m = d & 8'h1F;
                2'h1:    m = d & 8'h3F;
                2'h2:    m = d & 8'h7F;
                default: m = d;
            endcase
            if (lc[`ULFC_LC_FPAR])
                ulfc_par = ~lc[`ULFC_LC_EVEN]; // see [RULE6]
            else if (lc[`ULFC_LC_EVEN])
                ulfc_par = ^m; // see [RULE5]
            else
                ulfc_par = ~(^m); // see [RULE5]
        end
    endfunction

    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go         = aw_have_r && w_have_r;
    assign wsel          = ulfc_sel(awaddr_r);
    assign tx_load       = wr_go && (wsel == 3'h2) && wstrb_r[0] && tx_ready;
    assign rx_read       = s_axi_arvalid && s_axi_arready &&
                           (ulfc_sel(s_axi_araddr) == 3'h2);
    assign rx_done       = tick_r && (rstate_r == R_STOP) && (rtcnt_r == `ULFC_OVS - 6'h01);

    // Write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r      <= 1'b0;
            w_have_r       <= 1'b0;
            awaddr_r       <= 4'h0;
            wdata_r        <= 32'h00000000;
            wstrb_r        <= 4'h0;
            s_axi_bvalid   <= 1'b0;
            s_axi_bresp    <= `ULFC_RESP_OK;
            line_control_r <= `ULFC_LC_RST;
            div_r          <= `ULFC_DIV_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wsel == 3'h4) ? `ULFC_RESP_ERR : `ULFC_RESP_OK;
                if (wsel == 3'h0 && wstrb_r[0])
                    line_control_r <= wdata_r[7:0];
                // Divisor only writable with the latch open
                if (wsel == 3'h1 && line_control_r[`ULFC_LC_DLAB]) begin // see [RULE1]
                    if (wstrb_r[0])
                        div_r[7:0] <= wdata_r[7:0];
                    if (wstrb_r[1])
                        div_r[15:8] <= wdata_r[15:8];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `ULFC_RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `ULFC_RESP_OK;
            case (ulfc_sel(s_axi_araddr))
                3'h0:    s_axi_rdata <= {24'h000000, line_control_r};
                3'h1:    s_axi_rdata <= line_control_r[`ULFC_LC_DLAB] ?
                                        {16'h0000, div_r} : 32'h00000000; // see [RULE1]
                3'h2:    s_axi_rdata <= {24'h000000, rx_data_r};
                3'h3:    s_axi_rdata <= {28'h0000000, perr_r, ferr_r, rx_valid_r, tx_ready};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `ULFC_RESP_ERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Sixteen ticks per bit; a divisor of zero behaves as one
    always @(posedge aclk) begin
        if (!aresetn) begin
            bcnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else if (bcnt_r + 16'h0001 >= div_r) begin
            bcnt_r <= 16'h0000;
            tick_r <= 1'b1;
        end else begin
            bcnt_r <= bcnt_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    ulfc_tx u_tx (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .tick         (tick_r),
        .load         (tx_load),
        .data         (wdata_r[7:0]),
        .line_control (line_control_r),
        .par_bit      (ulfc_par(line_control_r, wdata_r[7:0])),
        .ready        (tx_ready),
        .txd_r        (txd_raw)
    );

    // Break overrides any character in flight
    always @(posedge aclk) begin
        if (!aresetn)
            txd_out <= 1'b1;
        else
            txd_out <= txd_raw & ~line_control_r[`ULFC_LC_BRK]; // see [RULE2]
    end

    // Pin synchroniser; level accepted once stages two and three agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_s3_r <= 1'b1;
            rxf_r   <= 1'b1;
        end else begin
            rx_s1_r <= rxd_in;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
            if (rx_s2_r == rx_s3_r)
                rxf_r <= rx_s3_r;
        end
    end

    // Receiver: samples mid-bit, format latched at start
    always @(posedge aclk) begin
        if (!aresetn) begin
            rstate_r <= R_IDLE;
            rtcnt_r  <= 6'h00;
            ridx_r   <= 3'h0;
            rsh_r    <= 8'h00;
            rlc_r    <= `ULFC_LC_RST;
            rperr_r  <= 1'b0;
        end else if (rstate_r == R_IDLE) begin
            if (!rxf_r) begin
                rstate_r <= R_START;
                rtcnt_r  <= 6'h00;
                rsh_r    <= 8'h00;
                rperr_r  <= 1'b0;
                rlc_r    <= line_control_r;
            end
        end else if (tick_r) begin
            if (rstate_r == R_START && rtcnt_r == `ULFC_HALF - 6'h01) begin
                rtcnt_r  <= 6'h00;
                ridx_r   <= 3'h0;
                rstate_r <= rxf_r ? R_IDLE : R_DATA;
            end else if (rstate_r != R_START && rtcnt_r == `ULFC_OVS - 6'h01) begin
                rtcnt_r <= 6'h00;
                case (rstate_r)
                    R_DATA: begin
                        rsh_r[ridx_r] <= rxf_r;
                        ridx_r        <= ridx_r + 3'h1;
                        if (ridx_r == 3'h4 + {1'b0, rlc_r[1:0]}) // see [RULE8]
                            rstate_r <= rlc_r[`ULFC_LC_PEN] ? R_PAR : R_STOP; // see [RULE3] [RULE4]
                    end
                    R_PAR: begin
                        rperr_r  <= (rxf_r != ulfc_par(rlc_r, rsh_r)); // see [RULE3]
                        rstate_r <= R_STOP;
                    end
                    default: begin
                        // Later stop bits are not waited for
                        rstate_r <= R_IDLE; // see [RULE9]
                    end
                endcase
            end else begin
                rtcnt_r <= rtcnt_r + 6'h01;
            end
        end
    end

    // Received character; a new arrival wins over the clearing read
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_data_r  <= 8'h00;
            rx_valid_r <= 1'b0;
            perr_r     <= 1'b0;
            ferr_r     <= 1'b0;
        end else if (rx_done) begin
            rx_data_r  <= rsh_r;
            rx_valid_r <= 1'b1;
            perr_r     <= rperr_r;
            ferr_r     <= !rxf_r; // see [RULE9]
        end else if (rx_read) begin
            rx_valid_r <= 1'b0;
        end
    end
endmodule // ulfc_top

`default_nettype wire

// ---- core/ulfc_tx.v ----
// Character transmitter driven by the 16x baud tick.
// Assumes load comes only while ready is high; break is applied by the parent.
`timescale 1ns/1ns
`default_nettype none
`include "ulfc_defines.vh"

module ulfc_tx (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       tick,
    input  wire       load,
    input  wire [7:0] data,
    input  wire [7:0] line_control,
    input  wire       par_bit,
    output wire       ready,
    output reg        txd_r
);
    localparam S_IDLE  = 3'h0;
    localparam S_START = 3'h1;
    localparam S_DATA  = 3'h2;
    localparam S_PAR   = 3'h3;
    localparam S_STOP  = 3'h4;

    reg  [2:0] state_r;
    reg  [5:0] tcnt_r;
    reg  [2:0] idx_r;
    reg  [7:0] shift_r;
    reg        par_r;
    reg  [7:0] lc_r;
    wire [5:0] stop_len;
    wire [5:0] bit_len;
    wire [2:0] last_idx;

    // Format is frozen per character so a mid-frame write cannot tear it
    assign stop_len = !lc_r[`ULFC_LC_STB] ? `ULFC_STOP1 :
                      (lc_r[1:0] == 2'h0) ? `ULFC_STOP15 : `ULFC_STOP2; // see [RULE7]
    assign bit_len  = (state_r == S_STOP) ? stop_len : `ULFC_OVS;
    assign last_idx = 3'h4 + {1'b0, lc_r[1:0]}; // see [RULE8]
    assign ready    = (state_r == S_IDLE);

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= S_IDLE;
            tcnt_r  <= 6'h00;
            idx_r   <= 3'h0;
            shift_r <= 8'h00;
            par_r   <= 1'b0;
            lc_r    <= `ULFC_LC_RST;
            txd_r   <= 1'b1;
        end else begin
            case (state_r)
                S_IDLE: begin
                    txd_r <= 1'b1;
                    if (load) begin
                        shift_r <= data;
                        par_r   <= par_bit;
                        lc_r    <= line_control;
                        tcnt_r  <= 6'h00;
                        state_r <= S_START;
                        txd_r   <= 1'b0;
                    end
                end
                default: begin
                    if (tick) begin
                        if (tcnt_r == bit_len - 6'h01) begin
                            tcnt_r <= 6'h00;
                            case (state_r)
                                S_START: begin
                                    idx_r   <= 3'h0;
                                    txd_r   <= shift_r[0];
                                    state_r <= S_DATA;
                                end
                                S_DATA: begin
                                    if (idx_r == last_idx) begin
                                        if (lc_r[`ULFC_LC_PEN]) begin // see [RULE3]
                                            txd_r   <= par_r;
                                            state_r <= S_PAR;
                                        end else begin // see [RULE4]
                                            txd_r   <= 1'b1;
                                            state_r <= S_STOP;
                                        end
                                    end else begin
                                        idx_r   <= idx_r + 3'h1;
                                        shift_r <= {1'b0, shift_r[7:1]};
                                        txd_r   <= shift_r[1];
                                    end
                                end
                                S_PAR: begin
                                    txd_r   <= 1'b1;
                                    state_r <= S_STOP;
                                end
                                default: begin
                                    state_r <= S_IDLE;
                                end
                            endcase
                        end else begin
                            tcnt_r <= tcnt_r + 6'h01;
                        end
                    end
                end
            endcase
        end
    end
endmodule // ulfc_tx

`default_nettype wire

// ---- dv/test_uart_line_format_control.sv ----
// Bench for the line control block: AXI-Lite master and frame checks.
// Assumes divisor 1 and the terminal model on the serial pins.
`timescale 1ns/1ns
`default_nettype none
`include "ulfc_defines.vh"
module test_uart_line_format_control;
    logic        aclk, aresetn, rxd, txd;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [23:0] f1, f2;
    logic [7:0]  l, d;
    longint      t1, t2;
    int          err_count, compares, cyc, n, lo, g;
    logic [7:0]  cfg [7] = '{8'h00, 8'h05, 8'h0A, 8'h1B, 8'h2C, 8'h3F, 8'h34};

    ulfc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rxd_in(rxd), .txd_out(txd));
    ulfc_term term (.aclk(aclk), .ser_in(txd), .ser_out(rxd));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] dv, output logic [1:0] rs);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= dv;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] dv, output logic [1:0] rs);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        dv = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // Expected frame bits, LSB first; m=1 flips parity, m=2 drops the stop
    function automatic logic [23:0] frm(input logic [7:0] lc, input logic [7:0] dd, input int m);
        int          w;
        logic [23:0] f;
        w = 5 + lc[1:0];
        f = '1;
        f[0] = 1'b0;
        for (int i = 0; i < w; i++)
            f[1 + i] = dd[i];
        if (lc[3]) f[1 + w] = (lc[5] ? !lc[4] : ^(dd & (8'hFF >> (3 - lc[1:0]))) ^ !lc[4]) ^ (m == 1);
        f[1 + w + lc[3]] = (m != 2);
        return f;
    endfunction
    task automatic complete_run;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Ceiling well above the roughly 5500 cycles the run needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            complete_run;
        end
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 40'h0;
        wstrb = 4'hF;
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ULFC_OFF_LC, v, r);
        chk(v, 32'h0);
        rd(`ULFC_OFF_DIV, v, r);
        chk(v, 32'h0);
        wr(`ULFC_OFF_LC, 32'h80, r);
        rd(`ULFC_OFF_DIV, v, r);
        chk(v, 32'h1);
        wr(`ULFC_OFF_LC, 32'h00, r);
        wr(`ULFC_OFF_DIV, 32'h7, r);
        wr(`ULFC_OFF_LC, 32'h80, r);
        rd(`ULFC_OFF_DIV, v, r);
        chk(v, 32'h1);
        rd(4'h2, v, r);
        chk({30'h0, r}, 32'h2);
        wr(4'h2, 32'h5, r);
        chk({30'h0, r}, 32'h2);
        wr(`ULFC_OFF_LC, 32'h40, r);
        repeat (20) @(posedge aclk);
        chk({31'h0, txd}, 32'h0);
        wr(`ULFC_OFF_LC, 32'h00, r);
        repeat (4) @(posedge aclk);
        chk({31'h0, txd}, 32'h1);
        for (int i = 0; i < 7; i++) begin
            l = cfg[i];
            d = 8'h35 + 8'(i) * 8'h1D;
            n = 7 + l[1:0] + l[3];
            lo = (n - 1) * 16 + (l[2] ? (l[1:0] == 2'h0 ? 24 : 32) : 16);
            wr(`ULFC_OFF_LC, {24'h0, l}, r);
            fork
                begin
                    term.grab(n, f1, t1);
                    term.grab(n, f2, t2);
                end
                begin
                    wr(`ULFC_OFF_DATA, {24'h0, d}, r);
                    do rd(`ULFC_OFF_STAT, v, r); while (v[0] !== 1'b1);
                    wr(`ULFC_OFF_DATA, 32'h0, r);
                end
            join
            g = (t2 - t1) / 20;
            chk({8'h0, f1}, {8'h0, frm(l, d, 0)});
            chk({8'h0, f2}, {8'h0, frm(l, 8'h00, 0)});
            chk(32'(g >= lo && g <= lo + 11), 32'h1);
            for (int m = 0; m < 3; m++) begin
                if (m == 1 && !l[3]) continue;
                term.send(frm(l, d, m), n);
                repeat (4) @(posedge aclk);
                rd(`ULFC_OFF_STAT, v, r);
                chk(v, {28'h0, m == 1, m == 2, 2'h3});
                rd(`ULFC_OFF_DATA, v, r);
                chk(v, {24'h0, d & (8'hFF >> (3 - l[1:0]))});
            end
        end
        // Two stops configured, next start follows a single stop
        wr(`ULFC_OFF_LC, 32'h07, r);
        f1 = frm(8'h07, 8'hA5, 0);
        f2 = frm(8'h07, 8'h3C, 0);
        term.send({f2[13:0], f1[9:0]}, 21);
        repeat (4) @(posedge aclk);
        rd(`ULFC_OFF_STAT, v, r);
        chk(v, 32'h3);
        rd(`ULFC_OFF_DATA, v, r);
        chk(v, 32'h3C);
        complete_run;
    end
endmodule // test_uart_line_format_control

bind ulfc_top ulfc_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .txd_out);
`default_nettype wire

// ---- dv/ulfc_chk.sv ----
// Checker on the AXI-Lite ports and the serial output of ulfc_top.
// Assumes whole-word writes and divisor 1, so one bit is 16 clocks.
`timescale 1ns/1ns
`default_nettype none
module ulfc_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        txd_out
);
    logic [7:0] lc_r, wd_r, hi_r, lo_r;
    logic [3:0] wa_r, ra_r;
    // Shadow lags the real register by one clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lc_r <= 8'h00;
            hi_r <= 8'hFF;
            lo_r <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[7:0];
            if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
            if ($rose(s_axi_bvalid) && wa_r == 4'h0 && s_axi_bresp == 2'h0) lc_r <= wd_r;
            // A break has no stop bit, so the mark after it may be short
            hi_r <= lc_r[6] ? 8'hFF : txd_out ? hi_r + (hi_r != 8'hFF) : 8'h00;
            lo_r <= (txd_out || lc_r[6]) ? 8'h00 : lo_r + 8'h01;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_break_hold: assert property (lc_r[6] && $past(lc_r[6]) |-> !txd_out)
        else $error("transmit line not low during break");
    chk_div_closed: assert property (s_axi_rvalid && ra_r == 4'h4 && !lc_r[7]
        |-> s_axi_rdata == 32'h0) else $error("divisor visible while latch closed");
    chk_lc_echo: assert property (s_axi_rvalid && ra_r == 4'h0
        |-> s_axi_rdata == {24'h0, lc_r}) else $error("line control readback wrong");
    chk_high_span: assert property ($fell(txd_out) && !lc_r[6] |-> hi_r >= 8'h10)
        else $error("high stretch shorter than one bit");
    chk_low_span: assert property (!txd_out && !lc_r[6] |-> lo_r < 8'hA0)
        else $error("low stretch longer than a frame allows");
    chk_b_late: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response late");
    chk_b_quiet: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_bad_waddr: assert property (s_axi_bvalid && wa_r[1:0] != 2'h0
        |-> s_axi_bresp == 2'h2) else $error("unmapped write not refused");
    chk_r_late: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read response late");
    chk_bad_addr: assert property (s_axi_rvalid && ra_r[1:0] != 2'h0
        |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    cov_break: cover property (lc_r[6] && !txd_out);
    cov_div_open: cover property (s_axi_rvalid && ra_r == 4'h4 && lc_r[7]);
    cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // ulfc_chk
`default_nettype wire

// ---- dv/ulfc_term.sv ----
// Remote terminal: shifts frames onto rxd and samples frames from txd.
// Assumes 16 clocks per bit; the line idles high as with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module ulfc_term (
    input  wire logic aclk,
    input  wire logic ser_in,
    output var  logic ser_out
);
    initial ser_out = 1'b1;
    task automatic send(input logic [23:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            ser_out <= bits[i];
            repeat (16) @(posedge aclk);
        end
        ser_out <= 1'b1;
    endtask
    // Returns at mid first stop, so a prompt next start is not missed
    task automatic grab(input int n, output logic [23:0] bits, output longint t);
        bits = '1;
        do @(posedge aclk); while (ser_in !== 1'b0);
        t = $time;
        for (int i = 0; i < n; i++) begin
            repeat (i == 0 ? 8 : 16) @(posedge aclk);
            bits[i] = ser_in;
        end
    endtask
endmodule // ulfc_term
`default_nettype wire
